// ==== design/wdf_watchdog.sv ====
// Watchdog feed unit: prescaler, 32-bit down-counter, mode, reload,
// feed and readback registers, feed checking and timeout actions.
// Assumes a master that keeps strobes one cycle long and never both at
// once; the chip reset request is fed back to us only through rst_n
// if the system wishes, since our own reset is handled internally.
//
// Notes on behaviour
// [RL1] Enable bit is set-only by software
// [RL2] Reset-on-timeout bit is set-only by software
// [RL3] Timeout flag survives watchdog reset, cleared externally
// [RL4] Interrupt flag is read-only, resets to zero
// [RL5] Software writes zeros to mode bits 7:4
// [RL6] Correct feed copies reload into counter
// [RL7] Reload register resets to 0xFF
// [RL8] Reload writes below 0xFF store 0xFF
// [RL9] Feed is 0xAA then 0x55, reload on second
// [RL10] Enable alone does not start; feed starts
// [RL11] Feed errors ignored until watchdog started
// [RL12] After 0xAA, any other access triggers
// [RL13] Feed error action in second clock after
// [RL14] Counter readback reads live count, 0xFF reset
// [RL15] Shortest timeout is 256 steps of four clocks
// [RL16] Counter decrements once per divide-by-four pulse
// [RL17] Underflow without reset mode raises interrupt
// [RL18] Underflow in reset mode resets chip, sets flag
// [RL19] Underflow or external reset clears both enables
// [RL20] Writing zero clears timeout flag; one ignored
// [RL21] Counter and prescaler hold until started
module wdf_watchdog (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire wdf_pkg::wdf_bus_s bus,
  output logic [31:0] rdata,
  // Timeout outputs
  output logic wdt_irq,
  output logic chip_reset_req
);

  // Address match helper
  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] off);
    hit = (a == off);
  endfunction

  // Register decode
  logic sel_mode; // Access to the mode register
  logic sel_reload; // Access to the reload register
  logic sel_feed; // Access to the feed register
  logic sel_count; // Access to the readback register
  logic any_acc; // Any access inside the watchdog space
  logic feed_wr_first; // Write of the first feed code
  logic feed_wr_second; // Write of the second feed code
  logic feed_ok; // Feed sequence completed this cycle
  logic bad_acc; // Wrong access while a feed is pending
  logic tick; // Prescaler output pulse
  logic uflow; // Counter steps below zero
  logic trip; // Timeout event from any cause
  logic soft_rst; // Watchdog-caused reset of the block

  // State
  logic enable_reg; // Watchdog enable, set-only
  logic rst_en_reg; // Reset-on-timeout enable, set-only
  logic tof_reg; // Timeout flag
  logic irq_reg; // Interrupt flag
  logic [31:0] reload_reg; // Reload constant
  logic [31:0] count_reg; // Down-counter
  logic [1:0] presc_reg; // Prescaler phase
  logic started_reg; // Set once a valid feed has run with enable
  logic armed_reg; // First feed code seen, second pending
  logic fault_reg; // Feed error waiting one cycle
  logic reset_req_reg; // Chip reset request pulse
  logic [31:0] rdata_reg; // Read data
  logic [31:0] reload_next; // Floored reload value

  // Decode of strobes and feed codes
  always_comb begin
    sel_mode = hit(bus.addr, wdf_pkg::ADDR_MODE);
    sel_reload = hit(bus.addr, wdf_pkg::ADDR_RELOAD);
    sel_feed = hit(bus.addr, wdf_pkg::ADDR_FEED);
    sel_count = hit(bus.addr, wdf_pkg::ADDR_COUNT);
    any_acc = (bus.wr || bus.rd) &&
              (sel_mode || sel_reload || sel_feed || sel_count);
    feed_wr_first = bus.wr && sel_feed &&
                    (bus.wdata[7:0] == wdf_pkg::FEED_FIRST);
    feed_wr_second = bus.wr && sel_feed &&
                     (bus.wdata[7:0] == wdf_pkg::FEED_SECOND);
    feed_ok = armed_reg && feed_wr_second; // RL9
    bad_acc = armed_reg && any_acc && !feed_wr_second; // RL12
  end

  // Timeout detection
  always_comb begin
    tick = started_reg && (presc_reg == wdf_pkg::PRESCALE_LAST); // RL16
    uflow = tick && (count_reg == 32'h0000_0000) && !feed_ok;
    trip = uflow || fault_reg;
    soft_rst = reset_req_reg;
  end

  // Reload floor: a small constant is raised to the minimum
  always_comb begin
    if (bus.wdata < wdf_pkg::RELOAD_MIN) begin // RL8
      reload_next = wdf_pkg::RELOAD_MIN;
    end else begin
      reload_next = bus.wdata;
    end
  end

  // Enable bit: software sets, timeout or reset clears
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      enable_reg <= 1'b0;
    end else if (trip) begin
      enable_reg <= 1'b0; // RL19
    end else if (bus.wr && sel_mode && bus.wdata[wdf_pkg::BIT_ENABLE]) begin
      enable_reg <= 1'b1; // RL1
    end
  end

  // Reset-on-timeout bit: same set-only scheme
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      rst_en_reg <= 1'b0;
    end else if (trip) begin
      rst_en_reg <= 1'b0; // RL19
    end else if (bus.wr && sel_mode && bus.wdata[wdf_pkg::BIT_RST_EN]) begin
      rst_en_reg <= 1'b1; // RL2
    end
  end

  // Timeout flag: only the external reset and software clear it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tof_reg <= 1'b0; // RL3
    end else if (trip && rst_en_reg) begin
      tof_reg <= 1'b1; // RL18
    end else if (bus.wr && sel_mode && !bus.wdata[wdf_pkg::BIT_TOF]) begin
      tof_reg <= 1'b0; // RL20
    end
  end

  // Interrupt flag: hardware sets it, any reset clears it
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      irq_reg <= 1'b0; // RL4
    end else if (trip && !rst_en_reg) begin
      irq_reg <= 1'b1; // RL17
    end
  end

  // Reload constant register
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      reload_reg <= wdf_pkg::RELOAD_RESET; // RL7
    end else if (bus.wr && sel_reload) begin
      reload_reg <= reload_next; // RL8
    end
  end

  // Feed tracking: arm on the first code, any access disarms
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      armed_reg <= 1'b0;
    end else if (any_acc) begin
      armed_reg <= feed_wr_first; // RL9
    end
  end

  // Start: first complete feed while enabled
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      started_reg <= 1'b0;
    end else if (trip) begin
      started_reg <= 1'b0;
    end else if (feed_ok && enable_reg) begin
      started_reg <= 1'b1; // RL10
    end
  end

  // Feed error is held one cycle so the action lands in the second
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= bad_acc && started_reg; // RL11 RL13
    end
  end

  // Prescaler: runs only while started, restarts on feed
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      presc_reg <= 2'h0;
    end else if (feed_ok || !started_reg) begin
      presc_reg <= 2'h0; // RL21
    end else begin
      presc_reg <= presc_reg + 2'h1; // RL16
    end
  end

  // Down-counter: reload on feed, step on tick, hold at zero
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      count_reg <= wdf_pkg::COUNT_RESET; // RL14
    end else if (feed_ok) begin
      count_reg <= reload_reg; // RL6
    end else if (tick && (count_reg != 32'h0000_0000)) begin
      count_reg <= count_reg - 32'h0000_0001; // RL15 RL16
    end
  end

  // Chip reset request, one cycle per trip in reset mode
  always_ff @(posedge clock) begin
    if (!rst_n || soft_rst) begin
      reset_req_reg <= 1'b0;
    end else begin
      reset_req_reg <= trip && rst_en_reg; // RL18
    end
  end

  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus.rd) begin
      if (sel_mode) begin
        rdata_reg <= {28'h0000000, irq_reg, tof_reg, rst_en_reg,
                      enable_reg}; // RL5
      end else if (sel_reload) begin
        rdata_reg <= reload_reg;
      end else if (sel_count) begin
        rdata_reg <= count_reg; // RL14
      end else begin
        rdata_reg <= 32'h0000_0000; // Feed and unmapped read zero
      end
    end else begin
      rdata_reg <= 32'h0000_0000;
    end
  end

  // Outputs straight from flip-flops
  assign rdata = rdata_reg;
  assign wdt_irq = irq_reg;
  assign chip_reset_req = reset_req_reg;

  // Checks on the guarded behaviour
  a_enable_sticky: assert property ( // RL1
    @(posedge clock) disable iff (!rst_n)
    enable_reg && !trip && !soft_rst |=> enable_reg)
    else $error("enable bit lost without timeout");

  a_rst_en_sticky: assert property ( // RL2
    @(posedge clock) disable iff (!rst_n)
    rst_en_reg && !trip && !soft_rst |=> rst_en_reg)
    else $error("reset enable lost without timeout");

  a_tof_survives: assert property ( // RL3
    @(posedge clock) disable iff (!rst_n)
    soft_rst && tof_reg && !(bus.wr && sel_mode) |=> tof_reg)
    else $error("timeout flag cleared by own reset");

  a_tof_set_cause: assert property ( // RL3
    @(posedge clock) disable iff (!rst_n)
    !tof_reg && !(trip && rst_en_reg) |=> !tof_reg)
    else $error("timeout flag set outside reset mode");

  a_irq_sticky: assert property ( // RL4
    @(posedge clock) disable iff (!rst_n)
    irq_reg && !soft_rst |=> irq_reg)
    else $error("interrupt flag lost without reset");

  a_irq_on_uflow: assert property ( // RL17
    @(posedge clock) disable iff (!rst_n)
    uflow && !rst_en_reg |=> irq_reg && !reset_req_reg)
    else $error("underflow did not raise interrupt");

  a_reset_on_uflow: assert property ( // RL18
    @(posedge clock) disable iff (!rst_n)
    uflow && rst_en_reg |=> reset_req_reg && tof_reg
      ##1 !enable_reg && count_reg == wdf_pkg::COUNT_RESET)
    else $error("underflow did not reset chip");

  a_reset_pulse: assert property ( // RL18
    @(posedge clock) disable iff (!rst_n)
    reset_req_reg |=> !reset_req_reg)
    else $error("chip reset request longer than one cycle");

  a_enables_clear: assert property ( // RL19
    @(posedge clock) disable iff (!rst_n)
    trip |=> !enable_reg && !rst_en_reg && !started_reg)
    else $error("timeout left enables set");

  a_reload_floor: assert property ( // RL8
    @(posedge clock) disable iff (!rst_n)
    bus.wr && sel_reload && !soft_rst |=>
      reload_reg == (($past(bus.wdata) < 32'h0000_00FF) ?
                     32'h0000_00FF : $past(bus.wdata)))
    else $error("reload floor not applied");

  a_reload_hold: assert property ( // RL7
    @(posedge clock) disable iff (!rst_n)
    !(bus.wr && sel_reload) && !soft_rst |=> $stable(reload_reg))
    else $error("reload constant moved without a write");

  a_feed_reload: assert property ( // RL6
    @(posedge clock) disable iff (!rst_n)
    armed_reg && feed_wr_second && !soft_rst |=>
      count_reg == $past(reload_reg) && presc_reg == 2'h0)
    else $error("feed did not reload counter");

  a_feed_fault_lat: assert property ( // RL13
    @(posedge clock) disable iff (!rst_n)
    bad_acc && started_reg && !trip && !soft_rst |=>
      !reset_req_reg && !$rose(irq_reg) ##1 (reset_req_reg || irq_reg))
    else $error("feed error action not in second clock");

  a_no_fault_early: assert property ( // RL11
    @(posedge clock) disable iff (!rst_n)
    bad_acc && !started_reg |=> !fault_reg)
    else $error("feed error acted before start");

  a_hold_idle: assert property ( // RL21
    @(posedge clock) disable iff (!rst_n)
    !started_reg && !feed_ok && !soft_rst |=>
      $stable(count_reg) && presc_reg == 2'h0)
    else $error("counter moved before start");

  a_step_hold: assert property ( // RL16
    @(posedge clock) disable iff (!rst_n)
    started_reg && !feed_ok && !soft_rst &&
      presc_reg != wdf_pkg::PRESCALE_LAST |=> $stable(count_reg))
    else $error("counter moved between prescaler pulses");

  a_step_spacing: assert property ( // RL15
    @(posedge clock) disable iff (!rst_n)
    started_reg && !feed_ok && !soft_rst &&
      presc_reg == wdf_pkg::PRESCALE_LAST && count_reg != 32'h0000_0000
      |=> count_reg == $past(count_reg) - 32'h0000_0001)
    else $error("counter did not step on prescaler pulse");

  a_presc_step: assert property ( // RL16
    @(posedge clock) disable iff (!rst_n)
    started_reg && !feed_ok && !soft_rst |=>
      presc_reg == $past(presc_reg) + 2'h1)
    else $error("prescaler did not advance by one");

  a_start_feed: assert property ( // RL10
    @(posedge clock) disable iff (!rst_n)
    enable_reg && !started_reg && !feed_ok |=> !started_reg)
    else $error("started without a feed");

  a_readback: assert property ( // RL14
    @(posedge clock) disable iff (!rst_n)
    bus.rd && sel_count |=> rdata == $past(count_reg))
    else $error("readback differs from counter");

endmodule // wdf_watchdog

// ==== design/wdf_pkg.sv ====
// Package for the watchdog feed unit: register map, field layout,
// reset values, feed codes and prescaler figures.
// Assumes a single 40 MHz peripheral clock and a plain register port.
package wdf_pkg;

  // Register byte addresses
  localparam logic [31:0] ADDR_MODE = 32'hE000_0000;
  localparam logic [31:0] ADDR_RELOAD = 32'hE000_0004;
  localparam logic [31:0] ADDR_FEED = 32'hE000_0008;
  localparam logic [31:0] ADDR_COUNT = 32'hE000_000C;

  // Mode register bit positions
  localparam int BIT_ENABLE = 0;
  localparam int BIT_RST_EN = 1;
  localparam int BIT_TOF = 2;
  localparam int BIT_IRQ = 3;

  // Reset values and the reload floor
  localparam logic [31:0] RELOAD_RESET = 32'h0000_00FF;
  localparam logic [31:0] COUNT_RESET = 32'h0000_00FF;
  localparam logic [31:0] RELOAD_MIN = 32'h0000_00FF;

  // Feed sequence codes, written to the low byte
  localparam logic [7:0] FEED_FIRST = 8'hAA;
  localparam logic [7:0] FEED_SECOND = 8'h55;

  // Prescaler: one counter step every four clocks
  localparam int PRESCALE_DIV = 4;
  localparam logic [1:0] PRESCALE_LAST = 2'(PRESCALE_DIV - 1);

  // Clock figure
  localparam int CLOCK_PERIOD_NS = 25;

  // One register port request from the processor side
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wdf_bus_s;

endpackage : wdf_pkg

// ==== verif/wdf_watchdog_bench.sv ====
// Self-checking bench for the watchdog feed unit: register port tasks,
// reset values, feed sequences, timeout in both modes.
// Assumes the design's own assertions sit inside the design files.
module wdf_watchdog_bench;
  timeunit 1ns;
  timeprecision 100ps;

  // Register addresses, shorthand
  localparam logic [31:0] a_mode = wdf_pkg::ADDR_MODE;
  localparam logic [31:0] a_rel = wdf_pkg::ADDR_RELOAD;
  localparam logic [31:0] a_feed = wdf_pkg::ADDR_FEED;
  localparam logic [31:0] a_cnt = wdf_pkg::ADDR_COUNT;

  // Clock, reset and register port
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  wdf_pkg::wdf_bus_s bus = '0;
  logic [31:0] rdata;
  logic wdt_irq;
  logic chip_reset_req;
  // Result counters
  int n_fail = 0;
  int samples_checked = 0;

  // Device under test
  wdf_watchdog u_dut (
    .clock(clock),
    .rst_n(rst_n),
    .bus(bus),
    .rdata(rdata),
    .wdt_irq(wdt_irq),
    .chip_reset_req(chip_reset_req)
  );

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // Word compare
  task automatic chk(input string nm, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Flag compare
  task automatic chkb(input string nm, input logic exp, got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // Write: strobe stands until the next task changes the port
  task automatic wr(input logic [31:0] a, d);
    @(posedge clock);
    bus <= '{a, d, 1'b1, 1'b0};
  endtask

  // Read: data is looked at in the one cycle it stands
  task automatic rd(input logic [31:0] a, exp, input string nm);
    @(posedge clock);
    bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
    @(posedge clock);
    bus <= '0;
    #1 chk(nm, exp, rdata);
  endtask

  // External reset held for eight cycles
  task automatic rst();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // Verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    end_sim();
  end

  // Main sequence; every write keeps bits 7:4 of mode at zero
  initial begin
    rst();
    rd(a_mode, 32'h0000_0000, "mode reset");
    rd(a_rel, 32'h0000_00FF, "reload reset");
    rd(a_cnt, 32'h0000_00FF, "count reset");
    wr(a_mode, 32'h0000_0008);
    rd(a_mode, 32'h0000_0000, "irq flag ro");
    wr(a_rel, 32'h0000_0010);
    rd(a_rel, 32'h0000_00FF, "reload floor");
    wr(a_mode, 32'h0000_0001);
    wr(a_mode, 32'h0000_0000);
    rd(a_mode, 32'h0000_0001, "enable sticky");
    // Malformed feed before start is ignored, count stays put
    wr(a_feed, 32'h0000_00AA);
    rd(a_mode, 32'h0000_0001, "early error");
    repeat (20) @(posedge clock);
    #1 chkb("irq early", 1'b0, wdt_irq);
    rd(a_cnt, 32'h0000_00FF, "held count");
    // Start in interrupt mode with the shortest interval
    wr(a_feed, 32'h0000_00AA);
    wr(a_feed, 32'h0000_0055);
    rd(a_cnt, 32'h0000_00FF, "fed count");
    repeat (1022) @(posedge clock);
    #1 chkb("irq before", 1'b0, wdt_irq);
    @(posedge clock);
    #1 chkb("irq timeout", 1'b1, wdt_irq);
    rd(a_mode, 32'h0000_0008, "mode tripped");
    rd(a_cnt, 32'h0000_0000, "count holds");
    rst();
    #1 chkb("irq cleared", 1'b0, wdt_irq);
    // Reset mode with a wide reload value
    wr(a_rel, 32'h1234_5678);
    wr(a_mode, 32'h0000_0003);
    wr(a_mode, 32'h0000_0000);
    rd(a_mode, 32'h0000_0003, "reset en sticky");
    wr(a_feed, 32'h0000_00AA);
    wr(a_feed, 32'h0000_0055);
    rd(a_cnt, 32'h1234_5678, "reload copy");
    // Unmapped read inside a feed is not a watchdog access
    wr(a_feed, 32'h0000_00AA);
    rd(32'hE000_0010, 32'h0000_0000, "unmapped");
    wr(a_feed, 32'h0000_0055);
    rd(a_mode, 32'h0000_0003, "no trip");
    // Wrong access after the first code trips the watchdog; the read
    // is taken at one edge, the request stands in the second cycle
    wr(a_feed, 32'h0000_00AA);
    rd(a_rel, 32'h1234_5678, "bad access");
    chkb("req early", 1'b0, chip_reset_req);
    @(posedge clock);
    #1 chkb("req pulse", 1'b1, chip_reset_req);
    repeat (2) @(posedge clock);
    rd(a_mode, 32'h0000_0004, "flag kept");
    rd(a_rel, 32'h0000_00FF, "reload own rst");
    rd(a_cnt, 32'h0000_00FF, "count own rst");
    wr(a_mode, 32'h0000_0004);
    rd(a_mode, 32'h0000_0004, "flag write one");
    wr(a_mode, 32'h0000_0000);
    rd(a_mode, 32'h0000_0000, "flag cleared");
    end_sim();
  end

endmodule // wdf_watchdog_bench
